/* verilog/ebt_pkg.sv */
// Purpose: Shared constants, states and helpers of the expansion bus access timing block.
// Assumes: Phase counts are the raw programmed values; durations are count plus an offset.
// Notes:   Every duration below is counted in cycles of ref_clk_i.
`default_nettype none
package ebt_pkg;

	// ==================================================================
	// Widths
	localparam int ADDR_W = 24;                 // Dedicated address lines
	localparam int DATA_W = 16;                 // Data lines, also carry address in mux mode
	localparam int CNT_W  = 5;                  // Phase counter, reaches 16 (recovery 17 cycles)

	// ==================================================================
	// Bus modes
	localparam logic [1:0] MODE_MUX     = 2'h0; // Strobe style, multiplexed, latch pulse
	localparam logic [1:0] MODE_SIMPLEX = 2'h1; // Strobe style, dedicated address lines
	localparam logic [1:0] MODE_HOST    = 2'h2; // 16-bit host port with ready-wait

	// ==================================================================
	// Phase offsets: phase length = programmed count + offset
	localparam logic [CNT_W-1:0] PHASE_EXTRA      = 5'h01; // Every phase except address hold and host port recovery
	localparam logic [CNT_W-1:0] HOST_RECOV_EXTRA = 5'h02; // Host port recovery 2..17
	localparam logic [CNT_W-1:0] AHOLD_LAST       = 5'h00; // Address hold after latch: 1 cycle

	// ==================================================================
	// Synchroniser and read capture
	localparam int SYNC_STAGES = 3;             // Pin inputs pass three flip-flops
	localparam int CAP_DELAY   = 3;             // Strobe end to synchronised data

	// ==================================================================
	// Reset values
	localparam logic [CNT_W-1:0]  CNT_RST  = 5'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
	localparam logic [1:0]        MODE_RST = 2'h0;
	localparam logic [3:0]        FLD_RST  = 4'h0;

	// ==================================================================
	// Access phases, one-hot
	typedef enum logic [6:0] {
		EBT_IDLE   = 7'h01,
		EBT_ADDR   = 7'h02,
		EBT_AHOLD  = 7'h04,
		EBT_SETUP  = 7'h08,
		EBT_STROBE = 7'h10,
		EBT_HOLD   = 7'h20,
		EBT_RECOV  = 7'h40
	} ebt_state_e;

	// Last counter value of a phase whose length is count + extra
	function automatic logic [CNT_W-1:0] ebt_phase_last(input logic [3:0] count,
			input logic [CNT_W-1:0] extra);
		ebt_phase_last = CNT_W'({1'b0, count} + extra - PHASE_EXTRA);
	endfunction

endpackage
`default_nettype wire

/* verilog/ebt_access_timing.sv */
// Purpose: Access phase timing generator for the expansion bus when it is master.
// Assumes: Software keeps host port counts in range; requests come from ref_clk_i logic.
// Notes:   Control pins decode the phase flip-flops; data lines come from flip-flops.
//
// Function
// - Latch pulse lasts address count plus one
// - Mux address held one cycle after latch
// - Chip select one cycle after latch
// - Strobe low for strobe count plus one
// - Hold phase keeps select, address, data
// - Write data precedes strobe by setup count plus one
// - Recovery of 1 to 16 idle cycles
// - No latch pulse in simplex modes
// - Simplex address precedes chip select
// - Host port phase lengths per table
// - Ready-wait accepted in address and strobe phases only
// - Stay in address/strobe while waiting
// - Address phase one more after wait
// - Strobe data one more after wait
// - Host address held with chip select
// - Host strobe follows chip select by setup
// - Host strobe width from strobe count
// - Host write data before strobe rises
// - Host data hold 1..4, recovery 2..17
`timescale 1ns/1ps
`default_nettype none
module ebt_access_timing
	import ebt_pkg::*;
(
	input  wire logic              ref_clk_i,                  // 250 MHz bus clock
	input  wire logic              rst_n_i,                    // Async reset, active low
	input  wire logic [1:0]        mode_i,                     // Bus mode select
	input  wire logic [1:0]        address_phase_count_i,      // Address phase count
	input  wire logic [1:0]        data_setup_phase_count_i,   // Setup phase count
	input  wire logic [3:0]        strobe_phase_count_i,       // Strobe phase count
	input  wire logic [1:0]        hold_phase_count_i,         // Hold phase count
	input  wire logic [3:0]        recovery_phase_count_i,     // Recovery phase count
	input  wire logic              req_valid_i,                // Access request
	input  wire logic              req_write_i,                // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] req_addr_i,                 // Access address
	input  wire logic [DATA_W-1:0] req_wdata_i,                // Write data
	output logic                   req_ready_o,                // Idle, request taken
	output logic                   done_o,                     // Access complete pulse
	output logic [DATA_W-1:0]      rdata_o,                    // Read data
	output logic                   busy_o,                     // Access in progress
	output logic [ADDR_W-1:0]      addr_o,                     // Address lines
	output logic                   cs_n_o,                     // Chip select, low active
	output logic                   rd_wr_n_o,                  // High read, low write
	output logic                   address_latch_pulse_o,      // Mux mode latch pulse
	output logic                   data_strobe_n_line_o,       // Strobe modes data strobe
	output logic                   host_data_strobe_one_n_o,   // Host port data strobe
	output logic [DATA_W-1:0]      data_o,                     // Data lines out
	output logic                   data_oe_o,                  // Data lines driven
	input  wire logic [DATA_W-1:0] data_i,                     // Data lines in
	input  wire logic              host_ready_wait_i           // Host asks for wait, high
);

	// ==================================================================
	// Declarations
	ebt_state_e        state;
	ebt_state_e        next_state;
	logic [CNT_W-1:0]  cnt;
	logic [CNT_W-1:0]  cur_last;
	logic [1:0]        mode_q;
	logic [1:0]        acnt_q;
	logic [1:0]        scnt_q;
	logic [3:0]        stcnt_q;
	logic [1:0]        hcnt_q;
	logic [3:0]        rcnt_q;
	logic              write_q;
	logic [DATA_W-1:0] req_wdata_hold;
	logic [SYNC_STAGES-1:0] wait_s;
	logic              wait_q;
	logic [DATA_W-1:0] data_s [SYNC_STAGES];
	logic [CAP_DELAY-1:0] cap_p;
	logic              host;
	logic              wait_hold;
	logic              take;

	assign host      = (mode_q == MODE_HOST);
	assign take      = req_valid_i && (state == EBT_IDLE);
	// Host may hold off only the address and strobe phases
	assign wait_hold = host && wait_q && (state == EBT_ADDR || state == EBT_STROBE);

	// ==================================================================
	// Ready-wait pin: three stages, a change counts once stages two and three agree
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_s <= '0;
			wait_q <= 1'b0;
		end else begin
			wait_s <= {wait_s[SYNC_STAGES-2:0], host_ready_wait_i};
			if (wait_s[1] == wait_s[2]) begin
				wait_q <= wait_s[2];
			end
		end
	end

	// Data pins: three plain stages with no agreement check, sampled late so the strobe edge is kept
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				data_s[i] <= DATA_RST;
			end
		end else begin
			data_s[0] <= data_i;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				data_s[i] <= data_s[i-1];
			end
		end
	end

	// ==================================================================
	// Configuration frozen at request time so a mid-access write cannot tear timing
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q  <= MODE_RST;
			acnt_q  <= FLD_RST[1:0];
			scnt_q  <= FLD_RST[1:0];
			stcnt_q <= FLD_RST;
			hcnt_q  <= FLD_RST[1:0];
			rcnt_q  <= FLD_RST;
			write_q <= 1'b0;
			addr_o  <= ADDR_RST;
		end else if (take) begin
			mode_q  <= mode_i;
			acnt_q  <= address_phase_count_i;
			scnt_q  <= data_setup_phase_count_i;
			stcnt_q <= strobe_phase_count_i;
			hcnt_q  <= hold_phase_count_i;
			rcnt_q  <= recovery_phase_count_i;
			write_q <= req_write_i;
			addr_o  <= req_addr_i; // Held through hold phase
		end
	end

	// ==================================================================
	// Last count of the current phase
	always_comb begin
		case (state)
			EBT_ADDR:   cur_last = ebt_phase_last({2'h0, acnt_q}, PHASE_EXTRA);
			EBT_AHOLD:  cur_last = AHOLD_LAST;
			EBT_SETUP:  cur_last = ebt_phase_last({2'h0, scnt_q}, PHASE_EXTRA);
			EBT_STROBE: cur_last = ebt_phase_last(stcnt_q, PHASE_EXTRA);
			EBT_HOLD:   cur_last = ebt_phase_last({2'h0, hcnt_q}, PHASE_EXTRA);
			EBT_RECOV:  cur_last = host ? ebt_phase_last(rcnt_q, HOST_RECOV_EXTRA)
			                            : ebt_phase_last(rcnt_q, PHASE_EXTRA);
			default:    cur_last = CNT_RST;
		endcase
	end

	// Phase sequence; only mux mode has the extra address hold cycle
	always_comb begin
		next_state = state;
		case (state)
			EBT_IDLE: begin
				if (req_valid_i) begin
					next_state = EBT_ADDR;
				end
			end
			EBT_ADDR: begin
				if (cnt == cur_last && !wait_hold) begin
					next_state = (mode_q == MODE_MUX) ? EBT_AHOLD : EBT_SETUP;
				end
			end
			EBT_AHOLD: begin
				next_state = EBT_SETUP;
			end
			EBT_SETUP: begin
				if (cnt == cur_last) begin
					next_state = EBT_STROBE;
				end
			end
			EBT_STROBE: begin
				if (cnt == cur_last && !wait_hold) begin
					next_state = EBT_HOLD;
				end
			end
			EBT_HOLD: begin
				if (cnt == cur_last) begin
					next_state = EBT_RECOV;
				end
			end
			EBT_RECOV: begin
				if (cnt == cur_last) begin
					next_state = EBT_IDLE;
				end
			end
			default: next_state = EBT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= EBT_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Phase counter; a wait seen on the last count steps back one, so at least one
	// more cycle follows the release. Relies on host address and strobe lasting 2+.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= CNT_RST;
		end else if (state != next_state) begin
			cnt <= CNT_RST;
		end else if (wait_hold) begin
			if (cnt == cur_last && cnt != CNT_RST) begin
				cnt <= cnt - PHASE_EXTRA;
			end
		end else if (state != EBT_IDLE) begin
			cnt <= cnt + PHASE_EXTRA;
		end
	end

	// ==================================================================
	// Data lines: address first in mux mode, write data from the setup phase on
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_o <= DATA_RST;
		end else if (take) begin
			data_o <= (mode_i == MODE_MUX) ? req_addr_i[DATA_W-1:0] : req_wdata_i;
		end else if (state == EBT_AHOLD) begin
			data_o <= req_wdata_hold;
		end
	end

	// Write data kept aside while the mux address occupies the lines
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_wdata_hold <= DATA_RST;
		end else if (take) begin
			req_wdata_hold <= req_wdata_i;
		end
	end

	// Control pins decode the phase flip-flops
	always_comb begin
		req_ready_o              = (state == EBT_IDLE);
		busy_o                   = (state != EBT_IDLE);
		cs_n_o                   = !(state == EBT_SETUP || state == EBT_STROBE
		                             || state == EBT_HOLD);
		rd_wr_n_o                = !(write_q && busy_o);
		address_latch_pulse_o    = (mode_q == MODE_MUX) && (state == EBT_ADDR);
		data_strobe_n_line_o     = !(!host && state == EBT_STROBE);
		host_data_strobe_one_n_o = !(host && state == EBT_STROBE);
		data_oe_o                = ((mode_q == MODE_MUX) && (state == EBT_ADDR
		                             || state == EBT_AHOLD))
		                           || (write_q && !cs_n_o);
	end

	// ==================================================================
	// Read capture: strobe end travels beside the synchronised data
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_p   <= '0;
			done_o  <= 1'b0;
			rdata_o <= DATA_RST;
		end else begin
			cap_p  <= {cap_p[CAP_DELAY-2:0], (state == EBT_STROBE && next_state == EBT_HOLD)};
			done_o <= cap_p[CAP_DELAY-1];
			if (cap_p[CAP_DELAY-1] && !write_q) begin
				rdata_o <= data_s[SYNC_STAGES-1];
			end
		end
	end

	// ==================================================================
	// Checks
	logic [2:0] ale_run;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ale_run <= 3'h0;
		end else begin
			ale_run <= address_latch_pulse_o ? 3'(ale_run + 3'h1) : 3'h0;
		end
	end

	ale_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(address_latch_pulse_o) |-> (ale_run == 3'({1'b0, acnt_q} + 3'h1)))
		else $error("latch pulse width differs from address count");
	mux_addr_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(address_latch_pulse_o) |-> data_oe_o && state == EBT_AHOLD ##1 state == EBT_SETUP)
		else $error("mux address not held exactly one cycle");
	cs_after_ale_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(address_latch_pulse_o) |-> cs_n_o ##1 !cs_n_o)
		else $error("chip select not one cycle after latch falls");
	strobe_width_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$rose(data_strobe_n_line_o) |-> $past(cnt) == {1'b0, stcnt_q} && !cs_n_o)
		else $error("strobe width differs from strobe count");
	setup_lead_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(data_strobe_n_line_o) && write_q |->
			$past(state) == EBT_SETUP && $past(cnt) == {3'h0, scnt_q} && $past(data_oe_o))
		else $error("write data lead before strobe wrong");
	hold_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		state == EBT_HOLD && next_state == EBT_RECOV |->
			cnt == {3'h0, hcnt_q} && !cs_n_o && (data_oe_o == write_q) ##1 cs_n_o)
		else $error("hold phase length or contents wrong");
	no_ale_simplex_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		mode_q != MODE_MUX |-> !address_latch_pulse_o)
		else $error("latch pulse outside mux mode");
	simplex_lead_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(cs_n_o) && mode_q == MODE_SIMPLEX |->
			$past(state) == EBT_ADDR && $past(cnt) == {3'h0, acnt_q})
		else $error("simplex address lead before select wrong");
	wait_stay_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wait_hold |=> state == $past(state))
		else $error("phase left while ready-wait held");
	wait_extra_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wait_hold ##1 !wait_hold |-> ##1 state == $past(state))
		else $error("no extra cycle after ready-wait release");
	host_cs_strobe_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$fell(host_data_strobe_one_n_o) && scnt_q >= 2'h2 |-> !$past(cs_n_o, 3) && !cs_n_o)
		else $error("host strobe too soon after chip select");
	recov_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		state == EBT_RECOV && next_state == EBT_IDLE |->
			cnt == (host ? 5'({1'b0, rcnt_q} + 5'h01) : {1'b0, rcnt_q}))
		else $error("recovery length wrong");

endmodule
`default_nettype wire

/* verif/ebt_peripheral_model.sv */
// Purpose: Far side of the expansion bus: a peripheral or a DSP host port.
// Assumes: Reads answer with the address folded by a fixed mask.
// Notes:   Undriven data toggles every cycle so that stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module ebt_peripheral_model
	import ebt_pkg::*;
(
	input  wire logic              ref_clk_i,         // Bus clock
	input  wire logic              rst_n_i,           // Reset, low active
	input  wire logic              cs_n_i,            // Chip select, low active
	input  wire logic              rd_wr_n_i,         // High read, low write
	input  wire logic              hstb_n_i,          // Host data strobe, low active
	input  wire logic [ADDR_W-1:0] addr_i,            // Address lines
	input  wire logic [3:0]        wait_len_i,        // Wait cycles per strobe, 0 none
	output logic      [DATA_W-1:0] data_o,            // Data driven toward the device
	output logic                   host_ready_wait_o  // Wait request, high
);
	logic       stb_q;
	logic [3:0] wcnt;

	// ==================================================================
	// Read data
	// Only valid while selected for a read; otherwise the lines keep moving
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			data_o <= 16'h0000;
		else if (!cs_n_i && rd_wr_n_i)
			data_o <= addr_i[15:0] ^ 16'h5a5a;
		else
			data_o <= ~data_o;
	end

	// ==================================================================
	// Wait request
	// Raised as the strobe falls, so a slow DSP stretches the strobe phase
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stb_q <= 1'b1;
			wcnt  <= 4'h0;
		end else begin
			stb_q <= hstb_n_i;
			if (stb_q && !hstb_n_i)
				wcnt <= wait_len_i;
			else if (wcnt != 4'h0)
				wcnt <= wcnt - 4'h1;
		end
	end
	assign host_ready_wait_o = (wcnt != 4'h0);
endmodule
`default_nettype wire

/* verif/tb_expansion_bus_access_timing.sv */
// Purpose: Self-checking bench for the expansion bus access timing block.
// Assumes: Requests are driven 1 ns after the rising edge; outputs read at the falling edge.
// Notes:   Phase lengths are measured on the pins and compared when busy drops.
`timescale 1ns/1ps
`default_nettype none
module tb_expansion_bus_access_timing import ebt_pkg::*;;
	typedef struct packed {
		logic [34:0]       tim;   // ale, gap, pre, strobe, hold, recovery, wrong line
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wd;
		logic [1:0]        mode;
		logic              wr;
		logic              loose; // Waits stretch the strobe by an unknown amount
	} ebt_note_s;

	logic ref_clk, rst_n, req_valid, req_write, req_ready, done, busy, cs_n, rd_wr_n;
	logic ale, dstb_n, hstb_n, doe, hwait, seen_cs, seen_stb, prev_ale;
	logic [1:0] mode, ac, sc, hc;
	logic [3:0] stc, rc, wlen;
	logic [ADDR_W-1:0] req_addr, addr;
	logic [DATA_W-1:0] req_wdata, rdata, dout, pdat, din;
	logic [4:0] c_ale, c_gap, c_pre, c_stb, c_hold, c_rec, c_wr;
	logic [34:0] got;
	logic [31:0] seed, x;
	wire logic stb;
	int n_fail, checks;
	ebt_note_s tq[$], rq[$], n, r;

	assign stb = !dstb_n || !hstb_n;
	// Data pins resolve between the device and the far side
	assign din = doe ? dout : pdat;

	ebt_access_timing i_ebt_access_timing (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .mode_i(mode),
		.address_phase_count_i(ac), .data_setup_phase_count_i(sc), .strobe_phase_count_i(stc),
		.hold_phase_count_i(hc), .recovery_phase_count_i(rc), .req_valid_i(req_valid),
		.req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
		.req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .busy_o(busy), .addr_o(addr),
		.cs_n_o(cs_n), .rd_wr_n_o(rd_wr_n), .address_latch_pulse_o(ale),
		.data_strobe_n_line_o(dstb_n), .host_data_strobe_one_n_o(hstb_n), .data_o(dout),
		.data_oe_o(doe), .data_i(din), .host_ready_wait_i(hwait));
	ebt_peripheral_model i_ebt_peripheral_model (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
		.cs_n_i(cs_n), .rd_wr_n_i(rd_wr_n), .hstb_n_i(hstb_n), .addr_i(addr), .wait_len_i(wlen),
		.data_o(pdat), .host_ready_wait_o(hwait));

	// ==================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out();
		if (tq.size() != 0 || rq.size() != 0)
			n_fail++;
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One access; a waited access is run alone so the wait length stays put
	task automatic acc(input logic [1:0] m, a, s, h, input logic [3:0] st, rv,
			input logic wr, input logic [3:0] wl);
		ebt_note_s e;
		logic [4:0] al;
		int k;
		al = {3'h0, a} + 5'h01;
		// A waited access starts from idle, so no earlier access sees its wait
		while (wl != 4'h0 && busy) begin
			req_valid = 1'b0;
			@(posedge ref_clk);
			#1;
		end
		mode = m;
		ac = a;
		sc = s;
		hc = h;
		stc = st;
		rc = rv;
		wlen = wl;
		req_write = wr;
		x = rnd();
		req_addr = x[23:0];
		x = rnd();
		req_wdata = x[15:0];
		e.tim = {(m == MODE_MUX) ? al : 5'h00, (m == MODE_MUX) ? 5'h01 : al, {3'h0, s} + 5'h01,
			{1'b0, st} + 5'h01, {3'h0, h} + 5'h01,
			{1'b0, rv} + ((m == MODE_HOST) ? 5'h02 : 5'h01), 5'h00};
		e.addr = req_addr;
		e.wd = req_wdata;
		e.mode = m;
		e.wr = wr;
		e.loose = (wl != 4'h0);
		req_valid = 1'b1;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (!req_ready && k < 200);
		if (!req_ready)
			n_fail++;
		@(posedge ref_clk);
		tq.push_back(e);
		rq.push_back(e);
		#1;
		if (wl != 4'h0) begin
			req_valid = 1'b0;
			do @(negedge ref_clk); while (busy);
			@(posedge ref_clk);
			#1;
		end
	endtask

	// ==================================================================
	// Watcher: pin phases per access, read data per completion
	always @(negedge ref_clk) begin
		if (busy && tq.size() > 0) begin
			n = tq[0];
			chk(rd_wr_n, !n.wr);
			if (ale)
				c_ale++;
			else if (cs_n && !seen_cs)
				c_gap++;
			if (!cs_n) begin
				seen_cs = 1'b1;
				chk(addr, n.addr);
				if (stb) begin
					c_stb++;
					seen_stb = 1'b1;
				end else if (!seen_stb)
					c_pre++;
				else
					c_hold++;
			end else if (seen_cs)
				c_rec++;
			if ((n.mode == MODE_HOST) ? !dstb_n : !hstb_n)
				c_wr++;
			if (stb && n.wr)
				chk({doe, dout}, {1'b1, n.wd});
			if (n.mode == MODE_MUX && (ale || prev_ale))
				chk({doe, dout}, {1'b1, n.addr[15:0]});
		end else if (!busy && tq.size() > 0 && seen_cs) begin
			n = tq.pop_front();
			got = {c_ale, c_gap, c_pre, c_stb, c_hold, c_rec, c_wr};
			if (n.loose && c_stb > n.tim[19:15])
				got[19:15] = n.tim[19:15];
			chk(got, n.tim);
		end
		if (!busy)
			{c_ale, c_gap, c_pre, c_stb, c_hold, c_rec, c_wr, seen_cs, seen_stb} = '0;
		prev_ale = ale;
		if (done) begin
			if (rq.size() == 0)
				chk(1, 0);
			else begin
				r = rq.pop_front();
				if (!r.wr)
					chk(rdata, r.addr[15:0] ^ 16'h5a5a);
			end
		end
	end

	// ==================================================================
	// Clock, watchdog and main sequence
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		#80000;
		n_fail++;
		close_out();
	end
	initial begin
		logic [2:0] m, k;
		int i;
		{rst_n, req_valid, req_write, mode, ac, sc, hc, stc, rc, wlen} = '0;
		{req_addr, req_wdata, n_fail, checks, seed} = {40'h0, 64'h0, 32'h25086b76};
		repeat (5) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		// Every mode at the shortest and longest counts, write and read, back to back
		for (m = 3'h0; m < 3'h4; m++)
			for (k = 3'h0; k < 3'h4; k++)
				if (k[1])
					acc(m[1:0], 2'h3, 2'h3, 2'h3, 4'hf, 4'hf, k[0], 4'h0);
				else if (m[1:0] == MODE_HOST)
					acc(m[1:0], 2'h2, 2'h2, 2'h0, 4'h1, 4'h0, k[0], 4'h0);
				else
					acc(m[1:0], 2'h0, 2'h0, 2'h0, 4'h0, 4'h0, k[0], 4'h0);
		acc(MODE_HOST, 2'h2, 2'h2, 2'h3, 4'h3, 4'h0, 1'b1, 4'h0);
		// Random modes and counts; host counts kept at their legal minimum or above
		for (i = 0; i < 24; i++) begin
			x = rnd();
			if (x[1:0] == MODE_HOST)
				acc(x[1:0], {1'b1, x[2]}, {1'b1, x[4]}, x[7:6], (x[11:8] == 4'h0) ? 4'h1 : x[11:8],
					x[15:12], x[16], 4'h0);
			else
				acc(x[1:0], x[3:2], x[5:4], x[7:6], x[11:8], x[15:12], x[16], 4'h0);
		end
		// The DSP holds off the strobe phase on a write and on a read
		acc(MODE_HOST, 2'h2, 2'h2, 2'h0, 4'h7, 4'h1, 1'b1, 4'hc);
		acc(MODE_HOST, 2'h3, 2'h3, 2'h1, 4'h7, 4'h2, 1'b0, 4'hc);
		req_valid = 1'b0;
		i = 0;
		while ((tq.size() != 0 || rq.size() != 0) && i < 200) begin
			@(posedge ref_clk);
			i++;
		end
		close_out();
	end
endmodule
`default_nettype wire
